//--- bsio_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the scan/io-test block
// Assumes: included by bare name from the package and the top module
// Notes:   register indices are word indices; byte address is four times the index
`ifndef BSIO_CFG_SVH
`define BSIO_CFG_SVH

// scan chain geometry
`define BSIO_IR_LEN        3
`define BSIO_BS_LEN        218
`define BSIO_ID_LEN        32
`define BSIO_CELL_HIZ      0
`define BSIO_CELL_OD_LO    3
`define BSIO_CELL_OD_HI    10

// instruction codes
`define BSIO_IR_EXTEST     3'h0
`define BSIO_IR_IDCODE     3'h1
`define BSIO_IR_SAMPLE     3'h2
`define BSIO_IR_SCANTEST   3'h5
`define BSIO_IR_CAPTURE    3'h1

// register indices (byte address = 4 * index)
`define BSIO_IDX_W         14
`define BSIO_IDX_DATA0     14'h2002
`define BSIO_IDX_CLKMODE1  14'h2004
`define BSIO_IDX_DATA1     14'h2802
`define BSIO_IDX_FRAME2    14'h2803
`define BSIO_IDX_ALARM2    14'h2804
`define BSIO_IDX_DATA2     14'h3002
`define BSIO_IDX_FRAME3    14'h3003
`define BSIO_IDX_ALARM3    14'h3004
`define BSIO_IDX_DATA3     14'h3802
`define BSIO_IDX_FRAME4    14'h3803
`define BSIO_IDX_ALARM4    14'h3804
`define BSIO_IDX_CTRL      14'h0100
`define BSIO_IDX_STATUS    14'h0101

// control register fields and reset value
`define BSIO_CTRL_IOTEST   0
`define BSIO_CTRL_RESET    1'h0

// timing: test clock half period and its least count of system cycles
`define BSIO_CLK_NS        20
`define BSIO_TCK_HALF_NS   80
`define BSIO_TCK_HALF_CYC  ((`BSIO_TCK_HALF_NS + `BSIO_CLK_NS - 1) / `BSIO_CLK_NS)

`endif

//--- bsio_pkg.sv
// Purpose: types shared by the scan/io-test block
// Assumes: bsio_cfg.svh gives the widths
// Notes:   all state of the top module is one packed struct
`include "bsio_cfg.svh"

package bsio_pkg;

   // sixteen-state test access port controller
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
      TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
      TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } bsio_tap_t;

   // observed input pins
   typedef struct packed {
      logic        hs_clk;
      logic        in_hs_n;
      logic        out_hs_n;
      logic [31:0] data;
      logic [3:0]  v5;
      logic [3:0]  tpl;
      logic [3:0]  ais;
      logic [3:0]  fm;
      logic [3:0]  pl;
      logic [3:0]  mf;
      logic [3:0]  par;
      logic [3:0]  omf;
   } bsio_pins_t;

   typedef struct packed {
      logic                      tck_s1;
      logic                      tck_s2;
      logic                      tck_s3;
      logic                      tms_s1;
      logic                      tms_s2;
      logic                      tdi_s1;
      logic                      tdi_s2;
      bsio_pins_t                pin_s1;
      bsio_pins_t                pin_s2;
      logic [`BSIO_BS_LEN-1:0]   bsp_s1;
      logic [`BSIO_BS_LEN-1:0]   bsp_s2;
      bsio_tap_t                 tap;
      logic [`BSIO_IR_LEN-1:0]   ir_sh;
      logic [`BSIO_IR_LEN-1:0]   ir;
      logic                      byp;
      logic [`BSIO_ID_LEN-1:0]   id_sh;
      logic [`BSIO_BS_LEN-1:0]   bs_sh;
      logic [`BSIO_BS_LEN-1:0]   bs_upd;
      logic                      tdo;
      logic                      tdo_oe_n;
      logic [7:0]                od;
      logic                      od_oe_n;
      logic                      io_test;
      logic                      pready;
      logic                      pslverr;
      logic [31:0]               prdata;
   } bsio_state_t;

endpackage

//--- bsio_top.sv
// Purpose: test access port with boundary scan, plus io-test read views of input pins over APB
// Assumes: tck, tms, tdi and all pins are asynchronous to ref_clk; tck half period >= 4 ref_clk cycles
// Notes:   ir/dr shift on synced tck rise, tdo and update act on synced tck fall
`timescale 1ns/100ps
`include "bsio_cfg.svh"

module bsio_top #(
   parameter int          IR_LEN     = `BSIO_IR_LEN,
   parameter int          BS_LEN     = `BSIO_BS_LEN,
   parameter logic [3:0]  ID_VERSION = 4'h2,      // arbitrary value
   parameter logic [15:0] ID_PART    = 16'hA5C3,  // arbitrary value
   parameter logic [10:0] ID_MAKER   = 11'h055    // arbitrary value
) (
   input  wire logic              ref_clk,
   input  wire logic              srst,
   // scan link
   input  wire logic              tck,
   input  wire logic              tms,
   input  wire logic              tdi,
   output      logic              tdo,
   output      logic              tdo_oe_n,
   // pin levels seen by the boundary cells
   input  wire logic [217:0]      bs_pin_levels,
   // output data bus of the first tributary
   input  wire logic [7:0]        core_output_data,
   output      logic [7:0]        output_data_bus,
   output      logic              output_data_oe_n,
   // observed input pins
   input  wire logic              high_speed_clock_in,
   input  wire logic              input_high_speed_select_n,
   input  wire logic              output_high_speed_select_n,
   input  wire logic [31:0]       input_data_bus,
   input  wire logic [3:0]        input_v5_marker,
   input  wire logic [3:0]        input_trib_payload_flag,
   input  wire logic [3:0]        input_alarm_indication,
   input  wire logic [3:0]        input_frame_marker,
   input  wire logic [3:0]        input_payload_flag,
   input  wire logic [3:0]        input_multiframe_marker,
   input  wire logic [3:0]        input_data_parity,
   input  wire logic [3:0]        output_multiframe_marker_in,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [15:0]       paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output      logic              pready,
   output      logic              pslverr,
   output      logic [31:0]       prdata
);

   // refuse geometries the logic was not built for
   if (IR_LEN != `BSIO_IR_LEN || BS_LEN != `BSIO_BS_LEN || `BSIO_CELL_OD_HI >= BS_LEN) begin : g_bad_geometry
      $error("bsio_top: unsupported chain lengths");
   end

   localparam logic [31:0] IDCODE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

   bsio_pkg::bsio_state_t q;
   bsio_pkg::bsio_state_t d;

   // standard tap transition on tms
   function automatic bsio_pkg::bsio_tap_t tap_next(input bsio_pkg::bsio_tap_t s, input logic m);
      case (s)
         bsio_pkg::TAP_RESET:    tap_next = m ? bsio_pkg::TAP_RESET    : bsio_pkg::TAP_IDLE;
         bsio_pkg::TAP_IDLE:     tap_next = m ? bsio_pkg::TAP_SEL_DR   : bsio_pkg::TAP_IDLE;
         bsio_pkg::TAP_SEL_DR:   tap_next = m ? bsio_pkg::TAP_SEL_IR   : bsio_pkg::TAP_CAP_DR;
         bsio_pkg::TAP_CAP_DR:   tap_next = m ? bsio_pkg::TAP_EXIT1_DR : bsio_pkg::TAP_SHIFT_DR;
         bsio_pkg::TAP_SHIFT_DR: tap_next = m ? bsio_pkg::TAP_EXIT1_DR : bsio_pkg::TAP_SHIFT_DR;
         bsio_pkg::TAP_EXIT1_DR: tap_next = m ? bsio_pkg::TAP_UPD_DR   : bsio_pkg::TAP_PAUSE_DR;
         bsio_pkg::TAP_PAUSE_DR: tap_next = m ? bsio_pkg::TAP_EXIT2_DR : bsio_pkg::TAP_PAUSE_DR;
         bsio_pkg::TAP_EXIT2_DR: tap_next = m ? bsio_pkg::TAP_UPD_DR   : bsio_pkg::TAP_SHIFT_DR;
         bsio_pkg::TAP_UPD_DR:   tap_next = m ? bsio_pkg::TAP_SEL_DR   : bsio_pkg::TAP_IDLE;
         bsio_pkg::TAP_SEL_IR:   tap_next = m ? bsio_pkg::TAP_RESET    : bsio_pkg::TAP_CAP_IR;
         bsio_pkg::TAP_CAP_IR:   tap_next = m ? bsio_pkg::TAP_EXIT1_IR : bsio_pkg::TAP_SHIFT_IR;
         bsio_pkg::TAP_SHIFT_IR: tap_next = m ? bsio_pkg::TAP_EXIT1_IR : bsio_pkg::TAP_SHIFT_IR;
         bsio_pkg::TAP_EXIT1_IR: tap_next = m ? bsio_pkg::TAP_UPD_IR   : bsio_pkg::TAP_PAUSE_IR;
         bsio_pkg::TAP_PAUSE_IR: tap_next = m ? bsio_pkg::TAP_EXIT2_IR : bsio_pkg::TAP_PAUSE_IR;
         bsio_pkg::TAP_EXIT2_IR: tap_next = m ? bsio_pkg::TAP_UPD_IR   : bsio_pkg::TAP_SHIFT_IR;
         bsio_pkg::TAP_UPD_IR:   tap_next = m ? bsio_pkg::TAP_SEL_DR   : bsio_pkg::TAP_IDLE;
         default:                tap_next = bsio_pkg::TAP_RESET;
      endcase
   endfunction

   // instruction decode, used by capture, shift and tdo selection
   function automatic logic ir_is_boundary(input logic [2:0] ir);
      ir_is_boundary = (ir == `BSIO_IR_EXTEST) || (ir == `BSIO_IR_SAMPLE) || (ir == `BSIO_IR_SCANTEST);
   endfunction

   // io-test view decode: {hit, byte}; reserved bits read as a stable zero
   function automatic logic [8:0] view_read(input logic [13:0] idx, input bsio_pkg::bsio_pins_t p);
      view_read = 9'h000;
      case (idx)
         `BSIO_IDX_DATA0:    view_read = {1'b1, p.data[7:0]};
         `BSIO_IDX_CLKMODE1: view_read = {1'b1, p.hs_clk, p.in_hs_n, p.out_hs_n,
                                          p.v5[0], p.tpl[0], p.ais[0], 2'b00};
         `BSIO_IDX_DATA1:    view_read = {1'b1, p.data[15:8]};
         `BSIO_IDX_DATA2:    view_read = {1'b1, p.data[23:16]};
         `BSIO_IDX_DATA3:    view_read = {1'b1, p.data[31:24]};
         `BSIO_IDX_FRAME2:   view_read = {2'b10, p.fm[1], p.pl[1], p.mf[1], p.par[1], p.omf[1], 2'b00};
         `BSIO_IDX_FRAME3:   view_read = {2'b10, p.fm[2], p.pl[2], p.mf[2], p.par[2], p.omf[2], 2'b00};
         `BSIO_IDX_FRAME4:   view_read = {2'b10, p.fm[3], p.pl[3], p.mf[3], p.par[3], p.omf[3], 2'b00};
         `BSIO_IDX_ALARM2:   view_read = {4'h8, p.v5[1], p.tpl[1], p.ais[1], 2'b00};
         `BSIO_IDX_ALARM3:   view_read = {4'h8, p.v5[2], p.tpl[2], p.ais[2], 2'b00};
         `BSIO_IDX_ALARM4:   view_read = {4'h8, p.v5[3], p.tpl[3], p.ais[3], 2'b00};
         default:            view_read = 9'h000;
      endcase
   endfunction

   logic                 tck_rise;
   logic                 tck_fall;
   logic                 extest_on;
   logic [13:0]          apb_idx;
   logic                 apb_acc;
   logic [BS_LEN-1:0]    bs_capture;
   logic [8:0]           view;

   // edges of the synchronised test clock
   assign tck_rise  = q.tck_s2 & ~q.tck_s3;
   assign tck_fall  = ~q.tck_s2 & q.tck_s3;
   assign extest_on = (q.ir == `BSIO_IR_EXTEST) && (q.tap != bsio_pkg::TAP_RESET);
   assign apb_idx   = paddr[15:2];
   assign apb_acc   = psel & penable & ~q.pready;
   assign view      = view_read(apb_idx, q.pin_s2);

   // capture vector: pin levels, with output data cells seeing the driven bus
   always_comb begin
      bs_capture = q.bsp_s2;
      bs_capture[`BSIO_CELL_OD_HI:`BSIO_CELL_OD_LO] = q.od;
   end

   // next state of the whole block
   always_comb begin
      d = q;
      // two-flop synchronisers
      d.tck_s1 = tck;
      d.tck_s2 = q.tck_s1;
      d.tck_s3 = q.tck_s2;
      d.tms_s1 = tms;
      d.tms_s2 = q.tms_s1;
      d.tdi_s1 = tdi;
      d.tdi_s2 = q.tdi_s1;
      d.pin_s1 = '{hs_clk: high_speed_clock_in, in_hs_n: input_high_speed_select_n,
                   out_hs_n: output_high_speed_select_n, data: input_data_bus,
                   v5: input_v5_marker, tpl: input_trib_payload_flag, ais: input_alarm_indication,
                   fm: input_frame_marker, pl: input_payload_flag, mf: input_multiframe_marker,
                   par: input_data_parity, omf: output_multiframe_marker_in};
      d.pin_s2 = q.pin_s1;
      d.bsp_s1 = bs_pin_levels;
      d.bsp_s2 = q.bsp_s1;

      // rising test clock edge: capture, shift, step the controller
      if (tck_rise) begin
         d.tap = tap_next(q.tap, q.tms_s2);
         case (q.tap)
            bsio_pkg::TAP_CAP_IR: begin
               d.ir_sh = `BSIO_IR_CAPTURE;
            end
            bsio_pkg::TAP_SHIFT_IR: begin
               d.ir_sh = {q.tdi_s2, q.ir_sh[IR_LEN-1:1]};
            end
            bsio_pkg::TAP_CAP_DR: begin
               if (q.ir == `BSIO_IR_IDCODE) begin
                  d.id_sh = IDCODE;
               end else if (ir_is_boundary(q.ir)) begin
                  d.bs_sh = bs_capture;
               end else begin
                  d.byp = 1'b0;
               end
            end
            bsio_pkg::TAP_SHIFT_DR: begin
               if (q.ir == `BSIO_IR_IDCODE) begin
                  d.id_sh = {q.tdi_s2, q.id_sh[`BSIO_ID_LEN-1:1]};
               end else if (ir_is_boundary(q.ir)) begin
                  d.bs_sh = {q.tdi_s2, q.bs_sh[BS_LEN-1:1]};
               end else begin
                  d.byp = q.tdi_s2;
               end
            end
            default: begin
            end
         endcase
      end

      // falling test clock edge: drive tdo, update registers
      if (tck_fall) begin
         d.tdo_oe_n = 1'b1;
         case (q.tap)
            bsio_pkg::TAP_SHIFT_IR: begin
               d.tdo      = q.ir_sh[0];
               d.tdo_oe_n = 1'b0;
            end
            bsio_pkg::TAP_SHIFT_DR: begin
               d.tdo_oe_n = 1'b0;
               if (q.ir == `BSIO_IR_IDCODE) begin
                  d.tdo = q.id_sh[0];
               end else if (ir_is_boundary(q.ir)) begin
                  d.tdo = q.bs_sh[0];
               end else begin
                  d.tdo = q.byp;
               end
            end
            bsio_pkg::TAP_UPD_IR: begin
               d.ir = q.ir_sh;
            end
            bsio_pkg::TAP_UPD_DR: begin
               if (q.ir == `BSIO_IR_EXTEST || q.ir == `BSIO_IR_SAMPLE) begin
                  d.bs_upd = q.bs_sh;
               end
            end
            bsio_pkg::TAP_RESET: begin
               d.ir = `BSIO_IR_IDCODE;
            end
            default: begin
            end
         endcase
      end

      // output data bus: core or boundary cells, cell 0 floats it
      d.od      = extest_on ? q.bs_upd[`BSIO_CELL_OD_HI:`BSIO_CELL_OD_LO] : core_output_data;
      d.od_oe_n = extest_on & q.bs_upd[`BSIO_CELL_HIZ];

      // APB: one wait state, answer on the second access cycle
      d.pready  = apb_acc;
      d.pslverr = 1'b0;
      d.prdata  = 32'h0000_0000;
      if (apb_acc) begin
         if (paddr[1:0] != 2'b00) begin
            d.pslverr = 1'b1;
         end else if (apb_idx == `BSIO_IDX_CTRL) begin
            if (pwrite && pstrb[0]) begin
               d.io_test = pwdata[`BSIO_CTRL_IOTEST];
            end
            d.prdata = {31'h0000_0000, q.io_test};
         end else if (apb_idx == `BSIO_IDX_STATUS) begin
            d.pslverr = pwrite;
            d.prdata  = {25'h0000000, q.ir, 4'(q.tap)};
         end else if (view[8]) begin
            d.pslverr = pwrite;
            d.prdata  = (q.io_test && !pwrite) ? {24'h000000, view[7:0]} : 32'h0000_0000;
         end else begin
            d.pslverr = 1'b1;
         end
      end

      // synchronous reset
      if (srst) begin
         d.tap      = bsio_pkg::TAP_RESET;
         d.ir       = `BSIO_IR_IDCODE;
         d.ir_sh    = `BSIO_IR_CAPTURE;
         d.byp      = 1'b0;
         d.id_sh    = '0;
         d.bs_sh    = '0;
         d.bs_upd   = '0;
         d.tdo      = 1'b0;
         d.tdo_oe_n = 1'b1;
         d.od       = 8'h00;
         d.od_oe_n  = 1'b0;
         d.io_test  = `BSIO_CTRL_RESET;
         d.pready   = 1'b0;
         d.pslverr  = 1'b0;
         d.prdata   = 32'h0000_0000;
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      q <= d;
   end

   // outputs straight from flip-flops
   assign tdo              = q.tdo;
   assign tdo_oe_n         = q.tdo_oe_n;
   assign output_data_bus  = q.od;
   assign output_data_oe_n = q.od_oe_n;
   assign pready           = q.pready;
   assign pslverr          = q.pslverr;
   assign prdata           = q.prdata;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   // ir capture loads the fixed pattern
   a_ir_capture_value: assert property (
      tck_rise && q.tap == bsio_pkg::TAP_CAP_IR |=> q.ir_sh == `BSIO_IR_CAPTURE)
      else $error("ir capture value wrong");

   // idcode capture loads the identity word
   a_idcode_capture: assert property (
      tck_rise && q.tap == bsio_pkg::TAP_CAP_DR && q.ir == `BSIO_IR_IDCODE |=> q.id_sh == IDCODE && q.id_sh[0])
      else $error("idcode capture wrong");

   // bypass capture clears the single bit
   a_bypass_capture: assert property (
      tck_rise && q.tap == bsio_pkg::TAP_CAP_DR && q.ir inside {3'h3, 3'h4, 3'h6, 3'h7} |=> !q.byp)
      else $error("bypass capture wrong");

   // sample capture takes the synchronised pin levels
   a_sample_capture: assert property (
      tck_rise && q.tap == bsio_pkg::TAP_CAP_DR && q.ir == `BSIO_IR_SAMPLE
      |=> q.bs_sh[BS_LEN-1:`BSIO_CELL_OD_HI+1] == $past(q.bsp_s2[BS_LEN-1:`BSIO_CELL_OD_HI+1]))
      else $error("sample capture wrong");

   // extest drives the bus from cells 3..10 one cycle later
   a_extest_drive: assert property (
      extest_on ##1 extest_on |-> q.od == $past(q.bs_upd[`BSIO_CELL_OD_HI:`BSIO_CELL_OD_LO]))
      else $error("extest drive wrong");

   // cell 0 under extest floats the bus
   a_hiz_control: assert property (
      extest_on && q.bs_upd[`BSIO_CELL_HIZ] |=> q.od_oe_n)
      else $error("global disable ignored");

   // outside scan drive the bus follows the core
   a_core_drive: assert property (
      !extest_on |=> q.od == $past(core_output_data) && !q.od_oe_n)
      else $error("core drive wrong");

   // a tms-high rise from select-ir or reset lands in reset, closing the five-rise walk
   a_tap_reset_walk: assert property (
      tck_rise && q.tms_s2 && (q.tap == bsio_pkg::TAP_SEL_IR || q.tap == bsio_pkg::TAP_RESET)
      |=> q.tap == bsio_pkg::TAP_RESET)
      else $error("tap did not reach reset");

   // update-ir copies the shifted code into the instruction
   a_ir_update_load: assert property (
      tck_fall && q.tap == bsio_pkg::TAP_UPD_IR |=> q.ir == $past(q.ir_sh))
      else $error("instruction update wrong");

   // test-logic reset selects the identity instruction
   a_reset_ir_idcode: assert property (
      tck_fall && q.tap == bsio_pkg::TAP_RESET |=> q.ir == `BSIO_IR_IDCODE)
      else $error("reset instruction wrong");

   // tdo is driven after a fall in a shift state
   a_tdo_drive_shift: assert property (
      tck_fall && (q.tap == bsio_pkg::TAP_SHIFT_DR || q.tap == bsio_pkg::TAP_SHIFT_IR) |=> !tdo_oe_n)
      else $error("tdo not driven in shift");

   // tdo is released after a fall outside shift
   a_tdo_release_idle: assert property (
      tck_fall && q.tap != bsio_pkg::TAP_SHIFT_DR && q.tap != bsio_pkg::TAP_SHIFT_IR |=> tdo_oe_n)
      else $error("tdo not released");

   // sample and extest update the boundary cells
   a_bs_update_load: assert property (
      tck_fall && q.tap == bsio_pkg::TAP_UPD_DR && (q.ir == `BSIO_IR_EXTEST || q.ir == `BSIO_IR_SAMPLE)
      |=> q.bs_upd == $past(q.bs_sh))
      else $error("boundary update wrong");

   // every access answers after one wait state, for one cycle
   a_apb_one_wait: assert property (
      apb_acc |=> pready ##1 !pready)
      else $error("apb answer timing wrong");

   // misaligned addresses are refused
   a_apb_misalign: assert property (
      apb_acc && paddr[1:0] != 2'b00 |=> pready && pslverr)
      else $error("misaligned access not refused");

   // view reads outside io test return zero, pready one cycle
   a_view_gated: assert property (
      apb_acc && view[8] && !pwrite && !q.io_test |=> pready && prdata == 32'h0000_0000 ##1 !pready)
      else $error("view read not gated");

endmodule

//--- bsio_tester.sv
// Purpose: board tester model that drives the scan link
// Assumes: link clock period 160 ns, clock held low between frames
// Notes:   tms/tdi change after the fall, tdo is taken just before the rise
`timescale 1ns/100ps
module bsio_tester (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe_n
);
   // idle link: clock still, tdi at its pull-up level
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h1;
   end

   // one link cycle: low 100 ns, high 60 ns
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #100;
      o = tdo_oe_n ? 1'h1 : tdo;  // released tdo reads as its pull-up level
      tck = 1'h1;
      #60;
      tck = 1'h0;
   endtask

   // n link cycles, bit i of m and d in cycle i; never lands on a system clock edge
   task automatic run(input int n, input logic [255:0] m, input logic [255:0] d, output logic [255:0] o);
      if ($time % 20 == 10) #7;
      for (int i = 0; i < n; i++) step(m[i], d[i], o[i]);
      tdi = 1'h1;
   endtask

   // five rises with tms high reach reset from anywhere, then idle
   task automatic reset_tap();
      logic [255:0] o;
      run(6, 256'h1F, '1, o);
   endtask

   // idle to shift-ir, three code bits, update, idle; returns captured bits
   task automatic ir(input logic [2:0] code, output logic [2:0] cap);
      logic [255:0] o;
      run(4, 256'h3, '1, o);
      run(5, 256'hC, {253'h0, code}, o);
      cap = o[2:0];
   endtask

   // idle to shift-dr, n bits with the last one leaving shift, update, idle
   task automatic dr(input int n, input logic [255:0] d, output logic [255:0] o);
      logic [255:0] x;
      run(3, 256'h1, '1, x);
      run(n + 2, 256'h3 << (n - 1), d, o);
   endtask
endmodule

//--- bsio_top_tb.sv
// Purpose: self-checking bench for the scan and io-test block
// Assumes: tester model drives the link; lfsr seed is fixed
// Notes:   expected values come from bench constants and functions only
`timescale 1ns/100ps
module bsio_top_tb;
   localparam logic [3:0]  VER   = 4'h2;     // arbitrary value
   localparam logic [15:0] PART  = 16'hA5C3; // arbitrary value
   localparam logic [10:0] MAKER = 11'h055;  // arbitrary value
   logic                 ref_clk = 1'h0;
   logic                 srst = 1'h1;
   logic                 tck, tms, tdi, tdo, tdo_oe_n, od_oe_n, pready, pslverr, err;
   logic                 psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [217:0]         bs_pins = '0;
   logic [7:0]           core = '0, od;
   logic [15:0]          paddr = '0, lfsr = 16'hD549;
   logic [31:0]          pwdata = '0, prdata, rd;
   logic [255:0]         din, dout, ev;
   logic [2:0]           cap;
   logic [2:0]           codes [6] = '{3'h3, 3'h4, 3'h6, 3'h7, 3'h5, 3'h2};
   bsio_pkg::bsio_pins_t pins = '0;
   int                   failures = 0, num_checks = 0;

   always #10 ref_clk = ~ref_clk;

   bsio_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) dut (
      .ref_clk(ref_clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
      .bs_pin_levels(bs_pins), .core_output_data(core), .output_data_bus(od), .output_data_oe_n(od_oe_n),
      .high_speed_clock_in(pins.hs_clk), .input_high_speed_select_n(pins.in_hs_n),
      .output_high_speed_select_n(pins.out_hs_n), .input_data_bus(pins.data), .input_v5_marker(pins.v5),
      .input_trib_payload_flag(pins.tpl), .input_alarm_indication(pins.ais), .input_frame_marker(pins.fm),
      .input_payload_flag(pins.pl), .input_multiframe_marker(pins.mf), .input_data_parity(pins.par),
      .output_multiframe_marker_in(pins.omf), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .pslverr(pslverr), .prdata(prdata));

   bsio_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

   // lfsr source of random words
   function automatic logic [31:0] rnd();
      logic [31:0] r;
      for (int i = 0; i < 32; i++) begin
         lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         r = {r[30:0], lfsr[0]};
      end
      return r;
   endfunction

   function automatic logic [255:0] fill();
      logic [255:0] v;
      for (int i = 0; i < 8; i++) v[32*i +: 32] = rnd();
      return v;
   endfunction

   // expected view byte: t picks the tributary, s the low index digit
   function automatic logic [7:0] exp_view(int t, int s);
      case (s)
         2: return pins.data[8*t +: 8];
         3: return {1'h0, pins.fm[t], pins.pl[t], pins.mf[t], pins.par[t], pins.omf[t], 2'h0};
         default: return {(t == 0) ? {pins.hs_clk, pins.in_hs_n, pins.out_hs_n} : 3'h0,
                          pins.v5[t], pins.tpl[t], pins.ais[t], 2'h0};
      endcase
   endfunction

   task automatic chk(string nm, logic [255:0] seen, logic [255:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task test_done();
      if (failures == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // one apb transfer held until pready; result left in rd and err
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'h1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         chk("pready", pready, 1'h1);
         test_done();
      end
   endtask

   // main sequence: scan paths first, then io-test views
   initial begin
      repeat (5) @(posedge ref_clk);
      srst <= 1'h0;
      din = fill();
      bs_pins <= din[217:0];
      core <= din[225:218];
      pins <= ~din[66:0];
      repeat (4) @(posedge ref_clk);
      apb(1'h0, 16'h0404, 32'h0);
      chk("status", rd, 32'h10);
      tester.reset_tap();
      tester.dr(32, '0, dout);
      chk("idcode", dout[31:0], {VER, PART, MAKER, 1'h1});
      for (int i = 0; i < 6; i++) begin
         tester.ir(codes[i], cap);
         chk("ir capture", cap, 3'h1);
         din = fill();
         din[8] = 1'h0;
         ev = {30'h0, din[7:0], bs_pins};
         ev[10:3] = core;
         if (i < 4) begin
            tester.dr(9, din, dout);
            chk("bypass", dout[8:0], {din[7:0], 1'h0});
         end else begin
            tester.dr(226, din, dout);
            chk("boundary", dout[225:0], ev[225:0]);
         end
      end
      tester.ir(3'h0, cap);
      chk("extest drive", {od_oe_n, od}, {1'h0, din[18:11]});
      ev = din;
      din = fill();
      din[0] = 1'h1;
      tester.dr(218, din, dout);
      chk("extest capture", dout[10:3], ev[18:11]);
      chk("output disable", od_oe_n, 1'h1);
      tester.reset_tap();
      chk("normal drive", {od_oe_n, od}, {1'h0, core});
      chk("tdo release", tdo_oe_n, 1'h1);
      apb(1'h0, 16'h8008, 32'h0);
      chk("view off", {err, rd}, 33'h0);
      apb(1'h1, 16'h8010, 32'h0);
      chk("view write", err, 1'h1);
      apb(1'h1, 16'h0400, 32'h1);
      apb(1'h0, 16'h0400, 32'h0);
      chk("ctrl", {err, rd}, 33'h1);
      apb(1'h0, 16'h8009, 32'h0);
      chk("misaligned", err, 1'h1);
      for (int r = 0; r < 3; r++) begin
         din = fill();
         pins <= din[66:0];
         repeat (4) @(posedge ref_clk);
         for (int t = 0; t < 4; t++) begin
            for (int s = 2; s < 5; s++) begin
               apb(1'h0, 16'(32'h8000 + t * 32'h2000 + s * 4), 32'h0);
               if (t == 0 && s == 3) chk("unmapped", err, 1'h1);
               else chk("view", {err, rd}, {25'h0, exp_view(t, s)});
            end
         end
      end
      // mid-run reset: tap back in reset, io test off again
      srst <= 1'h1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'h0;
      apb(1'h0, 16'h0404, 32'h0);
      chk("status after reset", rd, 32'h10);
      apb(1'h0, 16'h8008, 32'h0);
      chk("view after reset", {err, rd}, 33'h0);
      test_done();
   end
endmodule
